// ===== common/frg_consts.vh
`ifndef FRG_CONSTS_VH
`define FRG_CONSTS_VH

// First word address of the fixed halting region; everything below it
// belongs to the concurrent-read region.
`define FRG_HALT_START   15'h7000

// First word address of the boot section for each boot_size_config code.
// Every value is at or above FRG_HALT_START.
`define FRG_BOOT_START_0 15'h7000
`define FRG_BOOT_START_1 15'h7800
`define FRG_BOOT_START_2 15'h7C00
`define FRG_BOOT_START_3 15'h7E00

// Lock pair {upper, lower}; one means unprogrammed.
`define FRG_LOCK_ERASED  2'h3
`define FRG_LOCK_UPPER   1
`define FRG_LOCK_LOWER   0

// Fields of a four-bit lock word {boot pair, app pair}.
`define FRG_LOCKW_APP_LSB  0
`define FRG_LOCKW_BOOT_LSB 2
`define FRG_LOCKW_ERASED   4'hF

// Store-program-memory operation kinds.
`define FRG_SPM_LOAD     2'h0
`define FRG_SPM_ERASE    2'h1
`define FRG_SPM_WRITE    2'h2
`define FRG_SPM_LOCK     2'h3

`endif

// ===== hw/frg_region_decode.v
`include "frg_consts.vh"
`default_nettype none

module frg_region_decode (
  // Word address to classify
  input  wire [14:0] addr,
  input  wire [1:0]  bootSizeCfg,
  // Classification
  output wire        inHaltRegion,
  output wire        inBootSection
);

  function [14:0] bootStart;
    input [1:0] cfg;
    begin
      case (cfg)
        2'h0:    bootStart = `FRG_BOOT_START_0;
        2'h1:    bootStart = `FRG_BOOT_START_1;
        2'h2:    bootStart = `FRG_BOOT_START_2;
        default: bootStart = `FRG_BOOT_START_3;
      endcase
    end
  endfunction

  assign inHaltRegion  = (addr >= `FRG_HALT_START);
  // Every boot start sits at or above the halting boundary.
  assign inBootSection = (addr >= bootStart(bootSizeCfg)); // R7

endmodule // frg_region_decode

`default_nettype wire

// ===== hw/frg_lock_check.v
`include "frg_consts.vh"
`default_nettype none

module frg_lock_check (
  // Lock pair of this section, {upper, lower}
  input  wire [1:0] lockSet,
  // Access description
  input  wire       spmTargetHere,
  input  wire       lpmTargetHere,
  input  wire       lpmFromOther,
  input  wire       execHere,
  input  wire       vecOther,
  // Verdicts
  output wire       spmDeny,
  output wire       lpmDeny,
  output wire       irqSuppress
);

  // A programmed lower bit forbids writes; pair 1/1 forbids nothing.
  assign spmDeny = spmTargetHere & ~lockSet[`FRG_LOCK_LOWER]; // R14 R18

  // A programmed upper bit forbids reads from code in the other section.
  assign lpmDeny = lpmTargetHere & lpmFromOther
                 & ~lockSet[`FRG_LOCK_UPPER]; // R15 R16 R19 R20

  // Same upper bit masks interrupts whose vectors live in the other
  // section while this section executes.
  assign irqSuppress = execHere & vecOther
                     & ~lockSet[`FRG_LOCK_UPPER]; // R15 R16 R19 R20

endmodule // frg_lock_check

`default_nettype wire

// ===== hw/frg_guard.v
// Contract
// R1 - Programming a concurrent-read page still serves halting-region code.
// R2 - A halting-region page operation stalls the CPU throughout.
// R3 - Any self-programming operation blocks reads of the concurrent region; only erase and write do here, lock-bit stores do not.
// R4 - Halt decision uses the programmed page's region, not the read address.
// R5 - Busy status reads one while the concurrent region is blocked.
// R6 - Software clears busy before touching concurrent-region code again.
// R7 - Boot section lies wholly inside the halting region for every size.
// R8 - Software masks or relocates interrupts during concurrent programming.
// R9 - Application and boot lock sets are programmed independently.
// R10 - Lock bits set by software or external modes; only chip erase clears.
// R11 - General write lock does not affect store-program-memory programming.
// R12 - General read/write lock does not restrict load or store accesses.
// R13 - Application lock 1/1 allows all accesses to the application section.
// R14 - Application lock 1/0 refuses writes there, reads still allowed.
// R15 - Application lock 0/0 refuses writes and boot-code reads; masks IRQs.
// R16 - Application lock 0/1 refuses boot-code reads; masks interrupts.
// R17 - Boot lock 1/1 allows all accesses to the boot section.
// R18 - Boot lock 1/0 refuses writes there, reads still allowed.
// R19 - Boot lock 0/0 refuses writes and application-code reads; masks IRQs.
// R20 - Boot lock 0/1 refuses application-code reads; masks interrupts.
// R21 - Erase and write start only from store instructions in boot code.
// R22 - Re-enable clears busy once programming has finished.
// R23 - Halt holds from start until flash completion, released next cycle.
`include "frg_consts.vh"
`default_nettype none

module frg_guard (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // Configuration
  input  wire [1:0]  bootSizeCfg,
  input  wire        ivecInBoot,
  input  wire [3:0]  nvLockInit,
  // Executing instruction and fetch
  input  wire [14:0] pcAddr,
  input  wire        fetchReq,
  input  wire [14:0] fetchAddr,
  // Load program memory
  input  wire        lpmReq,
  input  wire [15:0] lpmAddr,
  // Store program memory
  input  wire        spmReq,
  input  wire [1:0]  spmKind,
  input  wire [14:0] spmAddr,
  input  wire [3:0]  spmLockData,
  // Flash array
  input  wire        flashDone,
  // Software and programming-mode controls
  input  wire        rwwReenable,
  input  wire        extLockWr,
  input  wire [3:0]  extLockData,
  input  wire        chipErase,
  // Flash array commands
  output reg         flashStart_r,
  output reg         flashErase_r,
  output reg  [14:0] flashPage_r,
  // CPU answers
  output reg         cpuHalt_r,
  output reg         regionBusy_r,
  output reg         fetchGrant_r,
  output reg         fetchRefused_r,
  output reg         lpmGrant_r,
  output reg         lpmRefused_r,
  output reg         spmRefused_r,
  output reg         irqSuppress_r,
  // Lock state
  output reg  [1:0]  appLockSet_r,
  output reg  [1:0]  bootLockSet_r
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_CONCUR = 2'h1;
  localparam [1:0] ST_HALT   = 2'h2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;

  wire        pcInBoot;
  wire        fetchInHalt;
  wire        lpmInHalt;
  wire        lpmInBoot;
  wire        spmInHalt;
  wire        spmInBoot;

  wire        appSpmDeny;
  wire        appLpmDeny;
  wire        appIrq;
  wire        bootSpmDeny;
  wire        bootLpmDeny;
  wire        bootIrq;

  wire        idle;
  wire        spmProg;
  wire        spmAccept;
  wire        spmLockCmd;
  wire        fetchBlocked;
  wire        lpmBlocked;

  reg  [3:0]  lockWord_nxt;
  reg         busy_nxt;
  reg         halt_nxt;

  // Address classification

  frg_region_decode uPcDecode (
    .addr          (pcAddr),
    .bootSizeCfg   (bootSizeCfg),
    .inHaltRegion  (),
    .inBootSection (pcInBoot)
  );

  frg_region_decode uFetchDecode (
    .addr          (fetchAddr),
    .bootSizeCfg   (bootSizeCfg),
    .inHaltRegion  (fetchInHalt),
    .inBootSection ()
  );

  frg_region_decode uLpmDecode (
    .addr          (lpmAddr[15:1]),
    .bootSizeCfg   (bootSizeCfg),
    .inHaltRegion  (lpmInHalt),
    .inBootSection (lpmInBoot)
  );

  frg_region_decode uSpmDecode (
    .addr          (spmAddr),
    .bootSizeCfg   (bootSizeCfg),
    .inHaltRegion  (spmInHalt),
    .inBootSection (spmInBoot)
  );

  // Lock checks, one per section, each on its own pair.

  frg_lock_check uAppLock (
    .lockSet       (appLockSet_r),
    .spmTargetHere (~spmInBoot),
    .lpmTargetHere (~lpmInBoot),
    .lpmFromOther  (pcInBoot),
    .execHere      (~pcInBoot),
    .vecOther      (ivecInBoot),
    .spmDeny       (appSpmDeny),
    .lpmDeny       (appLpmDeny),
    .irqSuppress   (appIrq)
  ); // R13

  frg_lock_check uBootLock (
    .lockSet       (bootLockSet_r),
    .spmTargetHere (spmInBoot),
    .lpmTargetHere (lpmInBoot),
    .lpmFromOther  (~pcInBoot),
    .execHere      (pcInBoot),
    .vecOther      (~ivecInBoot),
    .spmDeny       (bootSpmDeny),
    .lpmDeny       (bootLpmDeny),
    .irqSuppress   (bootIrq)
  ); // R17

  // Store requests

  assign idle = (state_r == ST_IDLE);

  assign spmProg = spmReq
                 & ((spmKind == `FRG_SPM_ERASE)
                 | (spmKind == `FRG_SPM_WRITE));

  // The general lock modes are not inputs here at all, so they can never
  // gate a store or load; only the two section lock pairs do.
  assign spmAccept = spmProg & pcInBoot & idle // R21
                   & ~appSpmDeny & ~bootSpmDeny; // R11 R12

  // A lock write through a store instruction must also come from boot
  // code, and is refused while the array is busy with a page.
  assign spmLockCmd = spmReq & (spmKind == `FRG_SPM_LOCK)
                    & pcInBoot & idle; // R21

  // Read blocking

  // The concurrent region stays unreadable until busy is cleared, which
  // covers the gap between completion and the software re-enable.
  assign fetchBlocked = (regionBusy_r & ~fetchInHalt) // R1 R3
                      | (state_r == ST_HALT); // R2

  assign lpmBlocked = (regionBusy_r & ~lpmInHalt) // R3
                    | (state_r == ST_HALT) // R2
                    | appLpmDeny | bootLpmDeny;

  // Operation state

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (spmAccept) begin
          // Region of the latched page decides, never the read address.
          if (spmInHalt) begin
            state_nxt = ST_HALT; // R4
          end else begin
            state_nxt = ST_CONCUR; // R4
          end
        end
      end
      ST_CONCUR: begin
        if (flashDone) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HALT: begin
        if (flashDone) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Halt and busy

  always @* begin
    // Halt rises with the accepted halting-region command and falls the
    // cycle after the flash reports completion.
    halt_nxt = (spmAccept & spmInHalt) // R2
             | ((state_r == ST_HALT) & ~flashDone); // R23
    // A new operation wins over a re-enable in the same cycle, and a
    // re-enable during an operation is ignored.
    busy_nxt = spmAccept // R3 R5
             | (regionBusy_r & ~(rwwReenable & idle)); // R22
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      cpuHalt_r    <= 1'b0;
      regionBusy_r <= 1'b0;
    end else begin
      cpuHalt_r    <= halt_nxt; // R23
      regionBusy_r <= busy_nxt; // R5
    end
  end

  // Flash commands

  always @(posedge clk_sys) begin
    if (reset) begin
      flashStart_r <= 1'b0;
      flashErase_r <= 1'b0;
      flashPage_r  <= 15'h0000;
    end else begin
      flashStart_r <= spmAccept;
      if (spmAccept) begin
        flashErase_r <= (spmKind == `FRG_SPM_ERASE);
        flashPage_r  <= spmAddr; // R4
      end
    end
  end

  // CPU answers

  always @(posedge clk_sys) begin
    if (reset) begin
      fetchGrant_r   <= 1'b0;
      fetchRefused_r <= 1'b0;
      lpmGrant_r     <= 1'b0;
      lpmRefused_r   <= 1'b0;
      spmRefused_r   <= 1'b0;
      irqSuppress_r  <= 1'b0;
    end else begin
      fetchGrant_r   <= fetchReq & ~fetchBlocked; // R1
      fetchRefused_r <= fetchReq & fetchBlocked; // R3
      lpmGrant_r     <= lpmReq & ~lpmBlocked;
      lpmRefused_r   <= lpmReq & lpmBlocked;
      spmRefused_r   <= (spmProg & ~spmAccept)
                      | (spmReq & (spmKind == `FRG_SPM_LOCK)
                      & ~spmLockCmd); // R21
      irqSuppress_r  <= appIrq | bootIrq; // R15 R16 R19 R20
    end
  end

  // Lock bits

  // Programming can only clear bits toward zero; the two pairs take their
  // own fields so one never disturbs the other.
  always @* begin
    lockWord_nxt = {bootLockSet_r, appLockSet_r};
    if (spmLockCmd) begin
      lockWord_nxt = lockWord_nxt & spmLockData; // R9 R10
    end
    if (extLockWr) begin
      lockWord_nxt = lockWord_nxt & extLockData; // R10
    end
    if (chipErase) begin
      lockWord_nxt = `FRG_LOCKW_ERASED; // R10
    end
  end

  // The pairs model non-volatile cells, so reset reloads them from the
  // stored value rather than forcing them open.
  always @(posedge clk_sys) begin
    if (reset) begin
      appLockSet_r  <= nvLockInit[`FRG_LOCKW_APP_LSB +: 2];
      bootLockSet_r <= nvLockInit[`FRG_LOCKW_BOOT_LSB +: 2];
    end else begin
      appLockSet_r  <= lockWord_nxt[`FRG_LOCKW_APP_LSB +: 2]; // R9
      bootLockSet_r <= lockWord_nxt[`FRG_LOCKW_BOOT_LSB +: 2]; // R9
    end
  end

endmodule // frg_guard

`default_nettype wire

// ===== tb/frg_guard_monitor.sv
`default_nettype none
module frg_guard_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Requests
  input wire logic        fetchReq,
  input wire logic [14:0] fetchAddr,
  input wire logic        spmReq,
  input wire logic [1:0]  spmKind,
  input wire logic [14:0] pcAddr,
  input wire logic        flashDone,
  input wire logic        rwwReenable,
  input wire logic        chipErase,
  // Answers
  input wire logic        flashStart_r,
  input wire logic [14:0] flashPage_r,
  input wire logic        cpuHalt_r,
  input wire logic        regionBusy_r,
  input wire logic        fetchGrant_r,
  input wire logic        fetchRefused_r,
  input wire logic        spmRefused_r,
  input wire logic [1:0]  appLockSet_r,
  input wire logic [1:0]  bootLockSet_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  fetch_answer_a: assert property (
    fetchReq |=> fetchGrant_r != fetchRefused_r) else $error("fetch answer");
  halt_refuse_a: assert property (
    cpuHalt_r && fetchReq |=> fetchRefused_r) else $error("halt fetch");
  busy_block_a: assert property (
    regionBusy_r && fetchReq && fetchAddr < 15'h7000 |=> fetchRefused_r)
    else $error("busy fetch");
  halt_page_a: assert property (
    flashStart_r |-> regionBusy_r && cpuHalt_r == (flashPage_r >= 15'h7000))
    else $error("halt page");
  busy_hold_a: assert property (
    regionBusy_r && !rwwReenable |=> regionBusy_r) else $error("busy drop");
  halt_hold_a: assert property (
    cpuHalt_r && !flashDone |=> cpuHalt_r) else $error("halt drop");
  halt_free_a: assert property (
    cpuHalt_r && flashDone |=> !cpuHalt_r) else $error("halt stuck");
  app_store_a: assert property (
    spmReq && spmKind == 2'h1 && pcAddr < 15'h7000 |=>
    spmRefused_r && !flashStart_r) else $error("app store");
  lock_sticky_a: assert property (
    !chipErase |=> ({bootLockSet_r, appLockSet_r}
    & ~$past({bootLockSet_r, appLockSet_r})) == 4'h0) else $error("lock up");
endmodule // frg_guard_monitor
bind frg_guard frg_guard_monitor u_frg_guard_monitor (.*);
`default_nettype wire

// ===== tb/frg_cpu_model.sv
`default_nettype none
module frg_cpu_model (
  // Clock, reset and status
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        regionBusy_r,
  input  wire logic        flashDone,
  // Requests
  output var  logic [14:0] pcAddr,
  output var  logic        fetchReq,
  output var  logic [14:0] fetchAddr,
  output var  logic        lpmReq,
  output var  logic [15:0] lpmAddr,
  output var  logic        spmReq,
  output var  logic [1:0]  spmKind,
  output var  logic [14:0] spmAddr,
  output var  logic [3:0]  spmLockData,
  output var  logic        rwwReenable
);
  timeunit 1ns;
  timeprecision 1ps;
  integer      seed = 32'h27A24EAE;
  logic [31:0] r;
  // Half the addresses are forced into the top block so every boot size is hit.
  function automatic logic [14:0] pick(input logic [31:0] v);
    pick = v[31] ? {3'h7, v[11:0]} : v[14:0];
  endfunction
  initial begin
    {pcAddr, fetchReq, fetchAddr, lpmReq, lpmAddr} = '0;
    {spmReq, spmKind, spmAddr, spmLockData, rwwReenable} = '0;
    forever begin
      @(negedge clk_sys);
      #1;
      r = $random(seed);
      pcAddr = pick($random(seed));
      fetchAddr = pick($random(seed));
      lpmAddr = {pick($random(seed)), r[0]};
      spmAddr = pick($random(seed));
      {fetchReq, lpmReq} = r[2:1] & {2{!reset}};
      spmKind = r[4:3];
      spmLockData = r[8:5] | r[12:9];
      // Lock stores also arrive during an operation, where they are refused.
      spmReq = r[13] && !reset && !flashDone;
      // Software only re-enables a region that reports busy.
      rwwReenable = &r[15:14] && regionBusy_r && !reset
                    && !flashDone;
    end
  end
endmodule // frg_cpu_model
`default_nettype wire

// ===== tb/frg_guard_tb.sv
`include "frg_consts.vh"
`default_nettype none
module frg_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, ivecInBoot, fetchReq, lpmReq, spmReq;
  logic        flashDone, rwwReenable, extLockWr, chipErase, flashStart_r;
  logic        flashErase_r, cpuHalt_r, regionBusy_r, fetchGrant_r;
  logic        fetchRefused_r, lpmGrant_r, lpmRefused_r, spmRefused_r;
  logic        irqSuppress_r, eAct;
  logic [1:0]  bootSizeCfg, spmKind, appLockSet_r, bootLockSet_r;
  logic [1:0]  eApp, eBoot;
  logic [3:0]  nvLockInit, spmLockData, extLockData;
  logic [9:0]  eBits, got;
  logic [14:0] pcAddr, fetchAddr, spmAddr, flashPage_r, ePage;
  logic [15:0] lpmAddr;
  logic [31:0] r;
  integer      n_mismatch = 0;
  integer      cmp_count = 0;
  frg_guard u_frg_guard (.*);
  frg_cpu_model u_frg_cpu_model (.*);
  // The interrupt mask is judged on the lock pairs held before the edge.
  assign got = {flashStart_r, flashErase_r, cpuHalt_r, regionBusy_r,
    fetchGrant_r, fetchRefused_r, lpmGrant_r, lpmRefused_r, spmRefused_r,
    irqSuppress_r};
  always @(posedge clk_sys) begin : model
    logic [14:0] bs;
    logic        xb, ok, wl;
    case (bootSizeCfg)
      2'h0: bs = `FRG_BOOT_START_0;
      2'h1: bs = `FRG_BOOT_START_1;
      2'h2: bs = `FRG_BOOT_START_2;
      default: bs = `FRG_BOOT_START_3;
    endcase
    xb = pcAddr >= bs;
    if (reset) begin
      {eBits, eAct, ePage} = '0;
      {eBoot, eApp} = nvLockInit;
    end else begin
      eBits[0] = ivecInBoot ? !xb && !eApp[1] : xb && !eBoot[1];
      eBits[4] = fetchReq && (eBits[7] || eBits[6]
                 && fetchAddr < `FRG_HALT_START);
      eBits[5] = fetchReq && !eBits[4];
      eBits[2] = lpmReq && (eBits[7] || eBits[6]
                 && lpmAddr[15:1] < `FRG_HALT_START
                 || (lpmAddr[15:1] >= bs ? !xb && !eBoot[1]
                 : xb && !eApp[1]));
      eBits[3] = lpmReq && !eBits[2];
      ok = spmReq && xb && !eAct && spmKind != `FRG_SPM_LOAD;
      wl = spmAddr >= bs ? !eBoot[0] : !eApp[0];
      eBits[9] = ok && spmKind != `FRG_SPM_LOCK && !wl;
      eBits[1] = spmReq && spmKind != `FRG_SPM_LOAD && !eBits[9]
                 && !(ok && spmKind == `FRG_SPM_LOCK);
      if (eBits[9]) begin
        eBits[8] = spmKind == `FRG_SPM_ERASE;
        eBits[7:6] = {spmAddr >= `FRG_HALT_START, 1'b1};
        ePage = spmAddr;
        eAct = 1'b1;
      end else if (eAct && flashDone)
        {eAct, eBits[7]} = 2'h0;
      else if (rwwReenable && !eAct)
        eBits[6] = 1'b0;
      if (chipErase)
        {eBoot, eApp} = `FRG_LOCKW_ERASED;
      else begin
        if (extLockWr)
          {eBoot, eApp} = {eBoot, eApp} & extLockData;
        if (ok && spmKind == `FRG_SPM_LOCK)
          {eBoot, eApp} = {eBoot, eApp} & spmLockData;
      end
    end
  end
  task automatic chk4(input logic [3:0] g, input logic [3:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t flags %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkPage(input logic [14:0] g, input logic [14:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t page %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Flash array: completion after 0 to 7 extra cycles, led by the page.
  initial begin
    flashDone = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (flashStart_r) begin
        repeat (flashPage_r[2:0]) @(negedge clk_sys);
        flashDone = 1'b1;
        @(negedge clk_sys);
        flashDone = 1'b0;
      end
    end
  end
  initial begin
    {reset, ivecInBoot, extLockWr, chipErase} = 4'h8;
    {bootSizeCfg, nvLockInit, extLockData} = 10'h0FF;
    repeat (10) @(negedge clk_sys);
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk_sys);
      chk4(got[9:6], eBits[9:6]);
      chk4(got[5:2], eBits[5:2]);
      chk4({2'h0, got[1:0]}, {2'h0, eBits[1:0]});
      chk4({bootLockSet_r, appLockSet_r}, {eBoot, eApp});
      chkPage(flashPage_r, ePage);
      #2;
      r = $random(u_frg_cpu_model.seed);
      reset = i >= 2000 && i < 2010;
      if (reset)
        nvLockInit = r[19:16];
      extLockWr = &r[2:0] && !spmReq;
      extLockData = r[6:3] | r[10:7];
      chipErase = r[15:11] == 5'h0;
      // Vectors and sections only move while no page is being programmed.
      if (i % 250 == 0 && !regionBusy_r)
        {ivecInBoot, bootSizeCfg} = r[22:20];
    end
    conclude();
  end
  initial begin
    #(6000 * 25);
    n_mismatch++;
    conclude();
  end
endmodule // frg_guard_tb
`default_nettype wire
